/* File: src/cef_top.sv */
// cef_top: fault flags, event masks and the interrupt pulse of a charger
// assumes a synchronous 8-bit register port from an I2C slave on CLK_IN
// and status inputs from logic on the same clock.
// Behaviour
// - over-voltage entry sets fault flag bit 7
// - thermal shutdown entry sets fault flag bit 6
// - safety timer expiry rise sets bit 4
// - reserved bits always read zero
// - conversion-done event counts only in one-shot; mask a bit 7 gates it
// - mask a bit 6 gates input-current regulation
// - mask a bit 5 gates input-voltage regulation
// - mask a bit 4 gates die temperature regulation
// - mask a bit 3 gates watchdog expiry rise
// - mask a bit 0 gates charge state change
// - mask b bit 7 gates power good toggle
// - mask b bit 4 gates input source change
// - mask b bit 2 gates thermistor zone change
// - mask b bit 1 gates optimizer rise
// - fault mask bits 7,6,4,3 gate fault rises
`timescale 1ns/10ps
module cef_top import cef_pkg::*; (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic REG_RESET_IN,
	input wire logic WATCHDOG_EXPIRE_IN,
	input wire cef_reg_req_t REG_REQ_IN,
	input wire cef_status_t STATUS_IN,
	output logic [7:0] REG_RDATA_OUT,
	output logic REG_RVALID_OUT,
	output logic INT_PULSE_OUT,
	output logic [NUM_EVENTS-1:0] EVENT_OUT
);
	logic input_overvoltage_flag_ff;
	logic thermal_shutdown_flag_ff;
	logic safety_timer_flag_ff;
	logic [7:0] mask_a_ff;
	logic [7:0] mask_b_ff;
	logic [7:0] fault_mask_ff;
	logic [7:0] fault_flags;
	logic [7:0] nxt_rdata;
	logic ovp_rise;
	logic tshut_rise;
	logic tmr_rise;
	logic sns_rise;
	logic ireg_rise;
	logic vreg_rise;
	logic die_temp_rise;
	logic wd_rise;
	logic chrg_chg;
	logic src_chg;
	logic ts_chg;
	logic pwr_good_chg;
	logic [NUM_EVENTS-1:0] raw_ev;
	logic [NUM_EVENTS-1:0] ev_mask;
	logic [NUM_EVENTS-1:0] qual_ev;
	logic clr_all;
	logic fault_rd;
	logic mask_a_wr;
	logic mask_b_wr;
	logic fault_mask_wr;

	function automatic logic [7:0] keep_used(input logic [7:0] v,
		input logic [7:0] used);
		keep_used = v & used;
	endfunction : keep_used

	// one decoder for every strobe, so reads and writes share the map
	function automatic logic hit(input logic strobe,
		input logic [7:0] addr, input logic [7:0] target);
		hit = strobe & (addr == target);
	endfunction : hit

	// fault entries are rising edges of their levels
	cef_edge #(.W(1)) u_ovp (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.sig_in(STATUS_IN.input_overvoltage),
		.rise_out(ovp_rise),
		.change_out()
	);
	cef_edge #(.W(1)) u_tshut (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.sig_in(STATUS_IN.thermal_shutdown),
		.rise_out(tshut_rise),
		.change_out()
	);
	cef_edge #(.W(1)) u_tmr (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.sig_in(STATUS_IN.safety_timer_expired),
		.rise_out(tmr_rise),
		.change_out()
	);
	cef_edge #(.W(1)) u_sns (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.sig_in(STATUS_IN.sense_short),
		.rise_out(sns_rise),
		.change_out()
	);
	// regulation entries and watchdog expiry use the same detector
	cef_edge #(.W(1)) u_ireg (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.sig_in(STATUS_IN.input_current_regulation),
		.rise_out(ireg_rise),
		.change_out()
	);
	cef_edge #(.W(1)) u_vreg (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.sig_in(STATUS_IN.input_voltage_regulation),
		.rise_out(vreg_rise),
		.change_out()
	);
	cef_edge #(.W(1)) u_die_temp (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.sig_in(STATUS_IN.die_temp_regulation),
		.rise_out(die_temp_rise),
		.change_out()
	);
	cef_edge #(.W(1)) u_wd (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.sig_in(STATUS_IN.watchdog_expired_status),
		.rise_out(wd_rise),
		.change_out()
	);
	cef_edge #(.W(3)) u_chrg (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.sig_in(STATUS_IN.charge_state_code),
		.rise_out(),
		.change_out(chrg_chg)
	);
	cef_edge #(.W(3)) u_src (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.sig_in(STATUS_IN.input_source_code),
		.rise_out(),
		.change_out(src_chg)
	);
	cef_edge #(.W(3)) u_ts (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.sig_in(STATUS_IN.thermistor_zone_code),
		.rise_out(),
		.change_out(ts_chg)
	);
	cef_edge #(.W(1)) u_pwr_good (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.sig_in(STATUS_IN.power_good),
		.rise_out(),
		.change_out(pwr_good_chg)
	);

	logic ico_rise;
	cef_edge #(.W(1)) u_ico (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.sig_in(STATUS_IN.optimizer_done),
		.rise_out(ico_rise),
		.change_out()
	);

	logic adc_rise;
	cef_edge #(.W(1)) u_adc (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.sig_in(STATUS_IN.conversion_done),
		.rise_out(adc_rise),
		.change_out()
	);

	// watchdog expiry is deliberately not a clear term
	assign clr_all = RST_IN | REG_RESET_IN;
	assign fault_rd = hit(REG_REQ_IN.rd, REG_REQ_IN.addr,
		FAULT_FLAGS_ADDR);
	assign mask_a_wr = hit(REG_REQ_IN.wr, REG_REQ_IN.addr, MASK_A_ADDR);
	assign mask_b_wr = hit(REG_REQ_IN.wr, REG_REQ_IN.addr, MASK_B_ADDR);
	assign fault_mask_wr = hit(REG_REQ_IN.wr, REG_REQ_IN.addr,
		FAULT_MASK_ADDR);

	// event order: 13..10 faults, 9..0 charger events
	always_comb begin
		raw_ev[13] = ovp_rise;
		raw_ev[12] = tshut_rise;
		raw_ev[11] = tmr_rise;
		raw_ev[10] = sns_rise;
		raw_ev[9] = ireg_rise;
		raw_ev[8] = vreg_rise;
		raw_ev[7] = die_temp_rise;
		raw_ev[6] = wd_rise;
		raw_ev[5] = chrg_chg;
		raw_ev[4] = pwr_good_chg;
		raw_ev[3] = src_chg;
		raw_ev[2] = ts_chg;
		raw_ev[1] = ico_rise;
		// conversion done counts only in one-shot mode
		raw_ev[0] = adc_rise & STATUS_IN.one_shot_mode;
	end

	// each event owns one mask bit; a set bit silences it
	always_comb begin
		ev_mask[13] = fault_mask_ff[OVP_BIT];
		ev_mask[12] = fault_mask_ff[TSHUT_BIT];
		ev_mask[11] = fault_mask_ff[TMR_BIT];
		ev_mask[10] = fault_mask_ff[SNS_BIT];
		ev_mask[9] = mask_a_ff[IREG_BIT];
		ev_mask[8] = mask_a_ff[VREG_BIT];
		ev_mask[7] = mask_a_ff[DIE_TEMP_BIT];
		ev_mask[6] = mask_a_ff[WD_BIT];
		ev_mask[5] = mask_a_ff[CHRG_BIT];
		ev_mask[4] = mask_b_ff[PWR_GOOD_BIT];
		ev_mask[3] = mask_b_ff[SRC_BIT];
		ev_mask[2] = mask_b_ff[TS_BIT];
		ev_mask[1] = mask_b_ff[ICO_BIT];
		ev_mask[0] = mask_a_ff[ADC_DONE_BIT];
	end

	// each event gated by its own mask bit only
	assign qual_ev = raw_ev & ~ev_mask;

	// set beats the read clear, so a fault in the read cycle survives
	// register reset wins over both; watchdog never reaches the flags
	always_ff @(posedge CLK_IN) begin
		if (clr_all) begin
			input_overvoltage_flag_ff <= FAULT_FLAGS_RST[OVP_BIT];
		end else if (ovp_rise) begin
			input_overvoltage_flag_ff <= 1'b1;
		end else if (fault_rd) begin
			input_overvoltage_flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (clr_all) begin
			thermal_shutdown_flag_ff <= FAULT_FLAGS_RST[TSHUT_BIT];
		end else if (tshut_rise) begin
			thermal_shutdown_flag_ff <= 1'b1;
		end else if (fault_rd) begin
			thermal_shutdown_flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (clr_all) begin
			safety_timer_flag_ff <= FAULT_FLAGS_RST[TMR_BIT];
		end else if (tmr_rise) begin
			safety_timer_flag_ff <= 1'b1;
		end else if (fault_rd) begin
			safety_timer_flag_ff <= 1'b0;
		end
	end

	// reserved flag positions are never stored
	always_comb begin
		fault_flags = 8'h00;
		fault_flags[OVP_BIT] = input_overvoltage_flag_ff;
		fault_flags[TSHUT_BIT] = thermal_shutdown_flag_ff;
		fault_flags[TMR_BIT] = safety_timer_flag_ff;
		fault_flags = keep_used(fault_flags, FAULT_FLAGS_USED);
	end

	// masks keep only writable bits, so reserved bits read zero
	always_ff @(posedge CLK_IN) begin
		if (clr_all) begin
			mask_a_ff <= MASK_A_RST;
		end else if (mask_a_wr) begin
			mask_a_ff <= keep_used(REG_REQ_IN.wdata, MASK_A_USED);
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (clr_all) begin
			mask_b_ff <= MASK_B_RST;
		end else if (mask_b_wr) begin
			mask_b_ff <= keep_used(REG_REQ_IN.wdata, MASK_B_USED);
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (clr_all) begin
			fault_mask_ff <= FAULT_MASK_RST;
		end else if (fault_mask_wr) begin
			fault_mask_ff <= keep_used(REG_REQ_IN.wdata,
				FAULT_MASK_USED);
		end
	end

	// unmapped addresses read as zero
	always_comb begin
		case (REG_REQ_IN.addr)
			FAULT_FLAGS_ADDR: nxt_rdata = fault_flags;
			MASK_A_ADDR: nxt_rdata = mask_a_ff;
			MASK_B_ADDR: nxt_rdata = mask_b_ff;
			FAULT_MASK_ADDR: nxt_rdata = fault_mask_ff;
			default: nxt_rdata = 8'h00;
		endcase
	end

	// read data registered, answer one cycle after the request
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			REG_RDATA_OUT <= 8'h00;
		end else if (REG_REQ_IN.rd) begin
			REG_RDATA_OUT <= nxt_rdata;
		end else begin
			REG_RDATA_OUT <= 8'h00;
		end
	end

	// valid stands for exactly the cycle that the data stands
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			REG_RVALID_OUT <= 1'b0;
		end else begin
			REG_RVALID_OUT <= REG_REQ_IN.rd;
		end
	end

	// simultaneous events merge into one pulse; EVENT_OUT tells them apart
	always_ff @(posedge CLK_IN) begin
		if (clr_all) begin
			INT_PULSE_OUT <= 1'b0;
		end else begin
			INT_PULSE_OUT <= |qual_ev;
		end
	end

	// pulse and vector share one qualified set, so they always agree
	always_ff @(posedge CLK_IN) begin
		if (clr_all) begin
			EVENT_OUT <= '0;
		end else begin
			EVENT_OUT <= qual_ev;
		end
	end
endmodule : cef_top

/* File: src/cef_pkg.sv */
// cef_pkg: register map, field positions and carriers for the charger
// event flag and mask block; assumes an 8-bit register port upstream.
package cef_pkg;
	localparam logic [7:0] FAULT_FLAGS_ADDR = 8'h11;
	localparam logic [7:0] MASK_A_ADDR = 8'h12;
	localparam logic [7:0] MASK_B_ADDR = 8'h13;
	localparam logic [7:0] FAULT_MASK_ADDR = 8'h14;
	localparam logic [7:0] FAULT_FLAGS_RST = 8'h00;
	localparam logic [7:0] MASK_A_RST = 8'h00;
	localparam logic [7:0] MASK_B_RST = 8'h00;
	localparam logic [7:0] FAULT_MASK_RST = 8'h00;
	// implemented bits; everything else reads zero
	localparam logic [7:0] FAULT_FLAGS_USED = 8'hD0;
	localparam logic [7:0] MASK_A_USED = 8'hF9;
	localparam logic [7:0] MASK_B_USED = 8'h96;
	localparam logic [7:0] FAULT_MASK_USED = 8'hD8;
	localparam int OVP_BIT = 7;
	localparam int TSHUT_BIT = 6;
	localparam int TMR_BIT = 4;
	localparam int SNS_BIT = 3;
	localparam int ADC_DONE_BIT = 7;
	localparam int IREG_BIT = 6;
	localparam int VREG_BIT = 5;
	localparam int DIE_TEMP_BIT = 4;
	localparam int WD_BIT = 3;
	localparam int CHRG_BIT = 0;
	localparam int PWR_GOOD_BIT = 7;
	localparam int SRC_BIT = 4;
	localparam int TS_BIT = 2;
	localparam int ICO_BIT = 1;
	localparam int NUM_EVENTS = 14;

	typedef struct packed {
		logic input_overvoltage;
		logic thermal_shutdown;
		logic safety_timer_expired;
		logic sense_short;
		logic input_current_regulation;
		logic input_voltage_regulation;
		logic die_temp_regulation;
		logic watchdog_expired_status;
		logic power_good;
		logic optimizer_done;
		logic conversion_done;
		logic one_shot_mode;
		logic [2:0] charge_state_code;
		logic [2:0] input_source_code;
		logic [2:0] thermistor_zone_code;
	} cef_status_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cef_reg_req_t;
endpackage : cef_pkg

/* File: src/cef_edge.sv */
// cef_edge: registers a status vector and reports rises and changes
// assumes inputs are already synchronous to CLK_IN
`timescale 1ns/10ps
module cef_edge import cef_pkg::*; #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [W-1:0] sig_in,
	output logic [W-1:0] rise_out,
	output logic change_out
);
	logic [W-1:0] prev_ff;
	logic primed_ff;

	// first cycle after reset only captures, so no false event
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			prev_ff <= '0;
			primed_ff <= 1'b0;
		end else begin
			prev_ff <= sig_in;
			primed_ff <= 1'b1;
		end
	end

	assign rise_out = primed_ff ? (sig_in & ~prev_ff) : '0;
	assign change_out = primed_ff & (sig_in != prev_ff);
endmodule : cef_edge

/* File: bench/cef_top_assertions.sv */
// cef_top_assertions: port checks for cef_top
// assumes a bind onto cef_top, one clock, sync reset
`timescale 1ns/10ps
module cef_top_assertions import cef_pkg::*; (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic REG_RESET_IN,
	input wire logic WATCHDOG_EXPIRE_IN,
	input wire cef_reg_req_t REG_REQ_IN,
	input wire cef_status_t STATUS_IN,
	input wire logic [7:0] REG_RDATA_OUT,
	input wire logic REG_RVALID_OUT,
	input wire logic INT_PULSE_OUT,
	input wire logic [NUM_EVENTS-1:0] EVENT_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	sequence flag_rd;
		REG_REQ_IN.rd && REG_REQ_IN.addr == FAULT_FLAGS_ADDR;
	endsequence
	sequence quiet;
		$stable(STATUS_IN);
	endsequence
	AST_FLAG_RSVD: assert property (flag_rd |=>
		REG_RVALID_OUT && (REG_RDATA_OUT & 8'h2F) == 8'h00)
		else $error("fault flag reserved bit set");
	AST_QUIET: assert property (quiet |=> !INT_PULSE_OUT)
		else $error("pulse without status change");
	AST_INT_EVT: assert property (INT_PULSE_OUT == (|EVENT_OUT))
		else $error("pulse and event vector disagree");
	AST_CONV: assert property (!STATUS_IN.one_shot_mode |=>
		!EVENT_OUT[0])
		else $error("conversion event outside one-shot");
	AST_PG: assert property (EVENT_OUT[4] |->
		$past(STATUS_IN.power_good) != $past(STATUS_IN.power_good, 2))
		else $error("power good event without toggle");
	AST_TSHUT: assert property (EVENT_OUT[12] |->
		$past(STATUS_IN.thermal_shutdown)
		&& !$past(STATUS_IN.thermal_shutdown, 2))
		else $error("shutdown event without rise");
	AST_REG_RST: assert property (REG_RESET_IN |=>
		!INT_PULSE_OUT && EVENT_OUT == '0)
		else $error("event after register reset");
	AST_RVALID: assert property (REG_REQ_IN.rd |=> REG_RVALID_OUT)
		else $error("read not answered");
endmodule : cef_top_assertions

/* File: bench/cef_status_src.sv */
// cef_status_src: charger-side status level model
// assumes the bench hands the next level on nxt_in
`timescale 1ns/10ps
module cef_status_src import cef_pkg::*; (
	input wire logic clk_in,
	input wire cef_status_t nxt_in,
	output cef_status_t status_out
);
	// levels move only on the clock, never mid-cycle
	always_ff @(posedge clk_in) begin
		status_out <= nxt_in;
	end
endmodule : cef_status_src

/* File: bench/cef_top_tb_top.sv */
// cef_top_tb_top: register and random status traffic for cef_top
// assumes cef_status_src shows a level one clock after it is set
`timescale 1ns/10ps
module cef_top_tb_top import cef_pkg::*; ();
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic reg_rst = 1'b0;
	logic wdog = 1'b0;
	cef_reg_req_t req = '0;
	cef_status_t nxt = '0;
	cef_status_t prv = '0;
	cef_status_t sts;
	logic [7:0] rdata, ma, mb, mf;
	logic rvalid, int_p;
	logic [13:0] ev;
	int num_errors = 0;
	int tests_run = 0;
	int seed = 44594;
	always #20 clk = ~clk;
	cef_status_src part_u (.clk_in(clk), .nxt_in(nxt), .status_out(sts));
	cef_top dut_u (.CLK_IN(clk), .RST_IN(rst), .REG_RESET_IN(reg_rst),
		.WATCHDOG_EXPIRE_IN(wdog), .REG_REQ_IN(req), .STATUS_IN(sts),
		.REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
		.INT_PULSE_OUT(int_p), .EVENT_OUT(ev));
	task automatic complete_run();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run
	task automatic cyc();
		@(posedge clk);
		#1;
	endtask : cyc
	task automatic chk8(logic [7:0] g, e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t read %h exp %h", $time, g, e);
		end
	endtask : chk8
	task automatic chkev(logic [14:0] g, e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t event %h exp %h", $time, g, e);
		end
	endtask : chkev
	// requests stay up until the next access, a step or a direct req clear replaces them
	task automatic wr(logic [7:0] a, d);
		req = '{1'b1, 1'b0, a, d};
		cyc();
	endtask : wr
	task automatic rd(logic [7:0] a, e);
		req = '{1'b0, 1'b1, a, 8'h00};
		cyc();
		chk8(rdata, e);
		chk8({7'h00, rvalid}, 8'h01);
	endtask : rd
	task automatic setm(logic [7:0] a, b, f);
		ma = a;
		mb = b;
		mf = f;
		wr(MASK_A_ADDR, a);
		wr(MASK_B_ADDR, b);
		wr(FAULT_MASK_ADDR, f);
	endtask : setm
	function automatic logic [14:0] exp_ev(logic [20:0] p, c);
		logic [20:0] r;
		logic [13:0] e, m;
		r = c & ~p;
		e = {r[20:13], c[8:6] != p[8:6], c[12] ^ p[12], c[5:3] != p[5:3],
			c[2:0] != p[2:0], r[11], r[10] & c[9]};
		m = {mf[7:6], mf[4:3], ma[6:3], ma[0], mb[7], mb[4], mb[2:1], ma[7]};
		e = e & ~m;
		return {|e, e};
	endfunction : exp_ev
	task automatic step(cef_status_t v);
		req = '0;
		nxt = v;
		cyc();
		cyc();
		chkev({int_p, ev}, exp_ev(prv, v));
		prv = v;
	endtask : step
	function automatic logic [7:0] rb(int b);
		return b == 0 ? 8'h00 : b == 1 ? 8'hFF : 8'($random(seed));
	endfunction : rb
	initial begin
		repeat (4) cyc();
		rst = 1'b0;
		cyc();
		for (int a = 17; a < 21; a++) rd(8'(a), 8'h00);
		rd(8'h20, 8'h00);
		wr(8'h11, 8'hFF);
		rd(8'h11, 8'h00);
		setm(8'h00, 8'h00, 8'hFF);
		step(21'h1C0000);
		rd(8'h11, 8'hD0);
		rd(8'h11, 8'h00);
		for (int b = 0; b < 6; b++) begin
			setm(rb(b), rb(b), rb(b));
			// wide random flips: many events share one pulse
			repeat (40) step(21'($random(seed)));
		end
		setm(8'hFF, 8'hFF, 8'hFF);
		req = '0;
		wdog = 1'b1;
		cyc();
		wdog = 1'b0;
		rd(8'h12, 8'hF9);
		rd(8'h13, 8'h96);
		rd(8'h14, 8'hD8);
		req = '0;
		reg_rst = 1'b1;
		cyc();
		reg_rst = 1'b0;
		for (int a = 18; a < 21; a++) rd(8'(a), 8'h00);
		{ma, mb, mf} = '0;
		step(~prv);
		complete_run();
	end
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		complete_run();
	end
endmodule : cef_top_tb_top
bind cef_top cef_top_assertions chk_u (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
	.REG_RESET_IN(REG_RESET_IN), .WATCHDOG_EXPIRE_IN(WATCHDOG_EXPIRE_IN),
	.REG_REQ_IN(REG_REQ_IN), .STATUS_IN(STATUS_IN),
	.REG_RDATA_OUT(REG_RDATA_OUT), .REG_RVALID_OUT(REG_RVALID_OUT),
	.INT_PULSE_OUT(INT_PULSE_OUT), .EVENT_OUT(EVENT_OUT));
